// ===== hw/rxs_stats.sv
// Top of the receive statistics counters with snapshot port.
// Assumes status arrives from receive path, filter and FIFO controller.
`timescale 1ns/1ps
module rxs_stats
   import rxs_pkg::*;
(
   input  wire logic                 CLOCK_I,
   input  wire logic                 RST_I,
   input  wire logic                 LITE_RESET_I,
   input  wire logic                 FRAME_END_I,
   input  wire logic [LEN_W-1:0]     FRAME_LEN_I,
   input  wire logic                 EXTRA_BITS_I,
   input  wire logic                 ETH_ERROR_I,
   input  wire logic [15:0]          TYPE_FIELD_I,
   input  wire logic [15:0]          INNER_TYPE_I,
   input  wire logic                 IS_UNICAST_I,
   input  wire logic                 IS_BROADCAST_I,
   input  wire logic                 IS_MULTICAST_I,
   input  wire logic                 IS_PAUSE_I,
   input  wire logic                 FILTER_PASS_I,
   input  wire logic                 FIFO_DROP_I,
   input  wire logic [LEN_W-1:0]     MAX_SIZE_I,
   input  wire logic                 VLAN_SIZE_ENFORCE_I,
   input  wire logic [15:0]          CUSTOM_TAG_ETHERTYPE_I,
   input  wire logic                 VLAN_STRIP_I,
   input  wire logic                 FCS_STRIP_I,
   input  wire logic                 FORWARD_PAUSE_SETTING_I,
   input  wire logic                 ACCEPT_BROADCAST_SETTING_I,
   input  wire logic                 STORE_BAD_FRAMES_I,
   input  wire logic                 SNAP_REQ_I,
   input  wire logic [3:0]           SNAP_SEL_I,
   output logic                      SNAP_VALID_O,
   output logic      [CW_BYTE-1:0]   SNAP_DATA_O
);
   typedef struct packed {
      logic [NUM_CNT-1:0][CW_BYTE-1:0] snap;
      logic                            valid;
      logic [CW_BYTE-1:0]              data;
   } rxs_top_state_type;

   rxs_top_state_type state_q;
   rxs_top_state_type state_d;

   logic                            any_rst;
   logic [NUM_CNT-1:0]              inc;
   logic [CW_BYTE-1:0]              bytes;
   logic [NUM_CNT-1:0][CW_BYTE-1:0] live;

   assign any_rst = RST_I || LITE_RESET_I;

   rxs_classify u_classify (
      .clk_i                      (CLOCK_I),
      .rst_i                      (any_rst),
      .frame_end_i                (FRAME_END_I),
      .frame_len_i                (FRAME_LEN_I),
      .extra_bits_i               (EXTRA_BITS_I),
      .eth_error_i                (ETH_ERROR_I),
      .type_field_i               (TYPE_FIELD_I),
      .inner_type_i               (INNER_TYPE_I),
      .is_unicast_i               (IS_UNICAST_I),
      .is_broadcast_i             (IS_BROADCAST_I),
      .is_multicast_i             (IS_MULTICAST_I),
      .is_pause_i                 (IS_PAUSE_I),
      .filter_pass_i              (FILTER_PASS_I),
      .fifo_drop_i                (FIFO_DROP_I),
      .max_size_i                 (MAX_SIZE_I),
      .vlan_size_enforce_i        (VLAN_SIZE_ENFORCE_I),
      .custom_tag_ethertype_i     (CUSTOM_TAG_ETHERTYPE_I),
      .vlan_strip_i               (VLAN_STRIP_I),
      .fcs_strip_i                (FCS_STRIP_I),
      .forward_pause_setting_i    (FORWARD_PAUSE_SETTING_I),
      .accept_broadcast_setting_i (ACCEPT_BROADCAST_SETTING_I),
      .store_bad_frames_i         (STORE_BAD_FRAMES_I),
      .inc_o                      (inc),
      .bytes_o                    (bytes)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
         if ((gi == IX_UC_BYTES) || (gi == IX_BC_BYTES) || (gi == IX_MC_BYTES)) begin : g_byte
            rxs_counter #(.WIDTH(CW_BYTE)) u_cnt (
               .clk_i     (CLOCK_I),
               .rst_i     (any_rst),
               .add_en_i  (inc[gi]),
               .add_val_i (bytes),
               .count_o   (live[gi])
            );
         end else begin : g_frame
            logic [CW_SMALL-1:0] cnt;
            rxs_counter #(.WIDTH(CW_SMALL)) u_cnt (
               .clk_i     (CLOCK_I),
               .rst_i     (any_rst),
               .add_en_i  (inc[gi]),
               .add_val_i (ONE_WORD),
               .count_o   (cnt)
            );
            assign live[gi] = {{(CW_BYTE-CW_SMALL){1'b0}}, cnt};
         end
      end
   endgenerate

   always_comb begin
      state_d       = state_q;
      state_d.valid = 1'b0;
      if (SNAP_REQ_I) begin
         state_d.snap  = live; // All counters caught in one cycle
         state_d.valid = 1'b1;
      end
      // Selections past the last counter read zero, also on a request cycle
      if (SNAP_SEL_I >= 4'(NUM_CNT)) begin
         state_d.data = ZERO_WORD;
      end else if (SNAP_REQ_I) begin
         state_d.data = live[SNAP_SEL_I];
      end else begin
         state_d.data = state_q.snap[SNAP_SEL_I];
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (any_rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign SNAP_VALID_O = state_q.valid;
   assign SNAP_DATA_O  = state_q.data;
endmodule : rxs_stats

// ===== hw/rxs_pkg.sv
// Constants and types for the receive statistics counters.
// Assumes a single 100 MHz clock and synchronous active-high reset.
package rxs_pkg;
   localparam int unsigned NUM_CNT   = 14;
   localparam int unsigned CW_SMALL  = 20;
   localparam int unsigned CW_BYTE   = 32;
   localparam int unsigned LEN_W     = 14;
   localparam logic [15:0] VLAN_TPID = 16'h8100;
   localparam logic [LEN_W-1:0] ONE_TAG_BYTES = 14'h0004;
   localparam logic [LEN_W-1:0] TWO_TAG_BYTES = 14'h0008;
   localparam logic [LEN_W-1:0] FCS_BYTES     = 14'h0004;
   localparam logic [LEN_W-1:0] LEN_64   = 14'h0040;
   localparam logic [LEN_W-1:0] LEN_65   = 14'h0041;
   localparam logic [LEN_W-1:0] LEN_127  = 14'h007f;
   localparam logic [LEN_W-1:0] LEN_128  = 14'h0080;
   localparam logic [LEN_W-1:0] LEN_255  = 14'h00ff;
   localparam logic [LEN_W-1:0] LEN_256  = 14'h0100;
   localparam logic [LEN_W-1:0] LEN_511  = 14'h01ff;
   // Counter indices, in snapshot order
   localparam int unsigned IX_OVERSIZE = 0;
   localparam int unsigned IX_DROPPED  = 1;
   localparam int unsigned IX_UC_BYTES = 2;
   localparam int unsigned IX_BC_BYTES = 3;
   localparam int unsigned IX_MC_BYTES = 4;
   localparam int unsigned IX_UC_FRM   = 5;
   localparam int unsigned IX_BC_FRM   = 6;
   localparam int unsigned IX_MC_FRM   = 7;
   localparam int unsigned IX_PAUSE    = 8;
   localparam int unsigned IX_BIN64    = 9;
   localparam int unsigned IX_BIN127   = 10;
   localparam int unsigned IX_BIN255   = 11;
   localparam int unsigned IX_BIN511   = 12;
   localparam int unsigned IX_SPARE    = 13;
   localparam logic [CW_BYTE-1:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [CW_BYTE-1:0] ONE_WORD  = 32'h0000_0001;
endpackage : rxs_pkg

// ===== hw/rxs_counter.sv
// One wrapping statistics counter with an add input.
// Assumes the increment is presented for exactly one cycle per frame.
`timescale 1ns/1ps
module rxs_counter
   import rxs_pkg::*;
#(
   parameter int unsigned WIDTH = CW_SMALL
)(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 add_en_i,
   input  wire logic [CW_BYTE-1:0]   add_val_i,
   output logic      [WIDTH-1:0]     count_o
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
   } rxs_cnt_state_type;

   rxs_cnt_state_type state_q;
   rxs_cnt_state_type state_d;

   always_comb begin
      state_d = state_q;
      if (add_en_i) begin
         state_d.count = state_q.count + add_val_i[WIDTH-1:0]; // Wraps
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign count_o = state_q.count;
endmodule : rxs_counter

// ===== hw/rxs_classify.sv
// Turns final frame status into per-counter increments, registered.
// Assumes status inputs are stable in the end-of-frame cycle.
`timescale 1ns/1ps
module rxs_classify
   import rxs_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 frame_end_i,
   input  wire logic [LEN_W-1:0]     frame_len_i,
   input  wire logic                 extra_bits_i,
   input  wire logic                 eth_error_i,
   input  wire logic [15:0]          type_field_i,
   input  wire logic [15:0]          inner_type_i,
   input  wire logic                 is_unicast_i,
   input  wire logic                 is_broadcast_i,
   input  wire logic                 is_multicast_i,
   input  wire logic                 is_pause_i,
   input  wire logic                 filter_pass_i,
   input  wire logic                 fifo_drop_i,
   input  wire logic [LEN_W-1:0]     max_size_i,
   input  wire logic                 vlan_size_enforce_i,
   input  wire logic [15:0]          custom_tag_ethertype_i,
   input  wire logic                 vlan_strip_i,
   input  wire logic                 fcs_strip_i,
   input  wire logic                 forward_pause_setting_i,
   input  wire logic                 accept_broadcast_setting_i,
   input  wire logic                 store_bad_frames_i,
   output logic      [NUM_CNT-1:0]   inc_o,
   output logic      [CW_BYTE-1:0]   bytes_o
);
   typedef struct packed {
      logic [NUM_CNT-1:0] inc;
      logic [CW_BYTE-1:0] bytes;
   } rxs_cls_state_type;

   rxs_cls_state_type state_q;
   rxs_cls_state_type state_d;

   logic             tag1;
   logic             tag2;
   logic [LEN_W-1:0] limit;
   logic [LEN_W-1:0] tag_bytes;
   logic [LEN_W-1:0] adj_len;
   logic             oversize;
   logic             good;
   logic             pause_held;
   logic             kept;
   logic             kept_bins;

   always_comb begin
      tag1 = (type_field_i == VLAN_TPID) || (type_field_i == custom_tag_ethertype_i);
      tag2 = tag1 && ((inner_type_i == VLAN_TPID) || (inner_type_i == custom_tag_ethertype_i));
      limit = max_size_i;
      if (vlan_size_enforce_i && tag2) begin
         limit = max_size_i + TWO_TAG_BYTES;
      end else if (vlan_size_enforce_i && tag1) begin
         limit = max_size_i + ONE_TAG_BYTES;
      end
      // Length counts whole bytes only, so trailing bits never tip it over
      oversize   = (frame_len_i > limit) && !eth_error_i;
      good       = !eth_error_i && !oversize;
      pause_held = is_pause_i && !forward_pause_setting_i;
      kept       = filter_pass_i && !pause_held && !fifo_drop_i;
      kept_bins  = filter_pass_i && !fifo_drop_i;
      tag_bytes  = tag2 ? TWO_TAG_BYTES : (tag1 ? ONE_TAG_BYTES : '0);
      adj_len    = frame_len_i;
      if (vlan_strip_i) begin
         adj_len = adj_len - tag_bytes;
      end
      if (fcs_strip_i) begin
         adj_len = adj_len - FCS_BYTES;
      end
      state_d       = '0;
      state_d.bytes = {{(CW_BYTE-LEN_W){1'b0}}, adj_len};
      if (frame_end_i) begin
         state_d.inc[IX_OVERSIZE] = oversize;
         state_d.inc[IX_DROPPED]  = fifo_drop_i && (!eth_error_i || store_bad_frames_i);
         // Same enable drives frame and byte counters of a class
         state_d.inc[IX_UC_FRM]   = good && kept && is_unicast_i;
         state_d.inc[IX_UC_BYTES] = good && kept && is_unicast_i;
         state_d.inc[IX_MC_FRM]   = good && kept && is_multicast_i;
         state_d.inc[IX_MC_BYTES] = good && kept && is_multicast_i;
         state_d.inc[IX_BC_FRM]   = good && is_broadcast_i && accept_broadcast_setting_i && !fifo_drop_i;
         state_d.inc[IX_BC_BYTES] = good && is_broadcast_i && accept_broadcast_setting_i && !fifo_drop_i;
         state_d.inc[IX_PAUSE]    = good && is_pause_i;
         state_d.inc[IX_BIN64]    = good && kept && (frame_len_i == LEN_64);
         state_d.inc[IX_BIN127]   = good && kept_bins && (frame_len_i >= LEN_65) && (frame_len_i <= LEN_127);
         state_d.inc[IX_BIN255]   = good && kept_bins && (frame_len_i >= LEN_128) && (frame_len_i <= LEN_255);
         state_d.inc[IX_BIN511]   = good && kept_bins && (frame_len_i >= LEN_256) && (frame_len_i <= LEN_511);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign inc_o   = state_q.inc;
   assign bytes_o = state_q.bytes;
endmodule : rxs_classify

// ===== testbench/rxs_stats_checker.sv
// Checker for the snapshot port of the receive statistics counters.
// Assumes it is bound to rxs_stats and sees only its ports.
`timescale 1ns/1ps
module rxs_stats_checker
   import rxs_pkg::*;
(
   input  wire logic                 CLOCK_I,
   input  wire logic                 RST_I,
   input  wire logic                 LITE_RESET_I,
   input  wire logic                 FRAME_END_I,
   input  wire logic                 SNAP_REQ_I,
   input  wire logic [3:0]           SNAP_SEL_I,
   input  wire logic                 SNAP_VALID_O,
   input  wire logic [CW_BYTE-1:0]   SNAP_DATA_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I || LITE_RESET_I);
   // Set once any frame has ended since the last reset
   logic seen_q;
   always_ff @(posedge CLOCK_I) begin
      seen_q <= (RST_I || LITE_RESET_I) ? 1'b0 : (seen_q || FRAME_END_I);
   end
   AST_SNAP_PULSE: assert property (SNAP_REQ_I |=> SNAP_VALID_O) else $error("valid missing");
   AST_NO_SPURIOUS: assert property (!SNAP_REQ_I |=> !SNAP_VALID_O) else $error("stray valid");
   AST_RST_CLEARS: assert property (disable iff (1'b0) (RST_I || LITE_RESET_I) |=>
      (SNAP_DATA_O == ZERO_WORD) && !SNAP_VALID_O) else $error("reset did not clear");
   AST_HIGH_SEL: assert property (SNAP_SEL_I >= 4'hd |=> SNAP_DATA_O == ZERO_WORD) else $error("spare not 0");
   AST_NARROW: assert property (SNAP_SEL_I inside {4'h0, 4'h1, [4'h5:4'hc]} |=>
      SNAP_DATA_O[31:20] == 12'h000) else $error("narrow counter too wide");
   AST_HOLD: assert property (!SNAP_REQ_I && !$past(SNAP_REQ_I) && $stable(SNAP_SEL_I) |=>
      $stable(SNAP_DATA_O)) else $error("snapshot moved");
   AST_FIRST_SNAP: assert property (($past(RST_I) || $past(LITE_RESET_I)) && SNAP_REQ_I |=>
      SNAP_DATA_O == ZERO_WORD ##1 SNAP_DATA_O == ZERO_WORD) else $error("first snapshot not 0");
   AST_NO_FRAME_ZERO: assert property (!seen_q && !FRAME_END_I && SNAP_REQ_I |=> ##1
      SNAP_DATA_O == ZERO_WORD) else $error("count without frame");
endmodule : rxs_stats_checker

bind rxs_stats rxs_stats_checker u_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .LITE_RESET_I(LITE_RESET_I),
   .FRAME_END_I(FRAME_END_I), .SNAP_REQ_I(SNAP_REQ_I), .SNAP_SEL_I(SNAP_SEL_I),
   .SNAP_VALID_O(SNAP_VALID_O), .SNAP_DATA_O(SNAP_DATA_O));

// ===== testbench/rxs_mac_model.sv
// Model of the receive path, filter and FIFO controller status feed.
// Assumes send is called at a rising edge of clk_i.
`timescale 1ns/1ps
module rxs_mac_model
   import rxs_pkg::*;
(
   input  wire logic              clk_i,
   output logic                   end_o,
   output logic [LEN_W-1:0]       len_o,
   output logic [3:0]             cls_o,
   output logic [3:0]             flg_o,
   output logic [15:0]            t1_o,
   output logic [15:0]            t2_o
);
   initial begin
      end_o = 1'b0;
      {len_o, cls_o, flg_o, t1_o, t2_o} = '0;
   end
   // cls is {unicast, broadcast, multicast, pause}; flg is {extra bits, error, drop, pass}
   task automatic send(input logic [LEN_W-1:0] len, input logic [3:0] cls, input logic [3:0] flg,
                       input logic [15:0] t1, input logic [15:0] t2);
      @(posedge clk_i);
      end_o <= 1'b1; // Final status only with the end strobe
      {len_o, cls_o, flg_o, t1_o, t2_o} <= {len, cls, flg, t1, t2};
      @(posedge clk_i);
      end_o <= 1'b0;
      // Status lines are not held once the strobe falls
      {len_o, cls_o, flg_o, t1_o, t2_o} <= ~{len, cls, flg, t1, t2};
      repeat (2) @(posedge clk_i);
   endtask : send
endmodule : rxs_mac_model

// ===== testbench/rxs_stats_tb_top.sv
// Self-checking testbench for the receive statistics counters.
// Assumes the MAC model feeds frame status; settings are driven here.
`timescale 1ns/1ps
module rxs_stats_tb_top;
   import rxs_pkg::*;
   logic                 clk, rst, lite_reset, enf, vstrip, fstrip, fwdp, ab, store, req, valid;
   logic [LEN_W-1:0]     max_size, flen;
   logic [15:0]          ctag, ft1, ft2;
   logic [3:0]           sel, fcls, fflg;
   logic                 fend;
   logic [CW_BYTE-1:0]   data;
   int                   miscompares = 0;
   int                   check_count = 0;
   rxs_mac_model mac (.clk_i(clk), .end_o(fend), .len_o(flen), .cls_o(fcls), .flg_o(fflg), .t1_o(ft1), .t2_o(ft2));
   rxs_stats dut (.CLOCK_I(clk), .RST_I(rst), .LITE_RESET_I(lite_reset), .FRAME_END_I(fend), .FRAME_LEN_I(flen),
      .EXTRA_BITS_I(fflg[3]), .ETH_ERROR_I(fflg[2]), .TYPE_FIELD_I(ft1), .INNER_TYPE_I(ft2),
      .IS_UNICAST_I(fcls[3]), .IS_BROADCAST_I(fcls[2]), .IS_MULTICAST_I(fcls[1]), .IS_PAUSE_I(fcls[0]),
      .FILTER_PASS_I(fflg[0]), .FIFO_DROP_I(fflg[1]), .MAX_SIZE_I(max_size), .VLAN_SIZE_ENFORCE_I(enf),
      .CUSTOM_TAG_ETHERTYPE_I(ctag), .VLAN_STRIP_I(vstrip), .FCS_STRIP_I(fstrip),
      .FORWARD_PAUSE_SETTING_I(fwdp), .ACCEPT_BROADCAST_SETTING_I(ab), .STORE_BAD_FRAMES_I(store),
      .SNAP_REQ_I(req), .SNAP_SEL_I(sel), .SNAP_VALID_O(valid), .SNAP_DATA_O(data));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Snapshot, then read one counter from it
   task automatic rd(input logic [3:0] s, input logic [31:0] exp);
      req <= 1'b1;
      sel <= s;
      @(posedge clk);
      req <= 1'b0;
      @(negedge clk);
      chk({31'h0, valid}, 32'h1);
      @(negedge clk);
      chk(data, exp);
      @(posedge clk);
   endtask : rd
   task automatic clr;
      lite_reset <= 1'b1;
      @(posedge clk);
      lite_reset <= 1'b0;
      rd(4'h2, 32'h0);
   endtask : clr
   task automatic t_bins;
      logic [LEN_W-1:0] lens [8] = '{14'h40, 14'h41, 14'h7f, 14'h80, 14'hff, 14'h100, 14'h1ff, 14'h200};
      logic [31:0] sum = 32'h0;
      foreach (lens[i]) begin
         mac.send(lens[i], 4'h8, 4'h1, 16'h0800, 16'h0800);
         sum += 32'(lens[i]);
      end
      rd(4'h9, 32'h1);
      for (int k = 10; k <= 12; k++) rd(4'(k), 32'h2);
      rd(4'h5, 32'h8);
      rd(4'h2, sum);
   endtask : t_bins
   task automatic t_filter;
      clr();
      fwdp <= 1'b0;
      mac.send(14'h50, 4'h8, 4'h0, 16'h0800, 16'h0800);
      mac.send(14'h50, 4'h2, 4'h3, 16'h0800, 16'h0800);
      mac.send(14'h40, 4'h3, 4'h1, 16'h8808, 16'h0000);
      mac.send(14'h40, 4'h9, 4'h0, 16'h8808, 16'h0000);
      for (int k = 2; k <= 9; k++) if (k != 3 && k != 6 && k != 8) rd(4'(k), 32'h0);
      rd(4'ha, 32'h0);
      rd(4'h8, 32'h2);
      rd(4'h1, 32'h1);
      fwdp <= 1'b1;
   endtask : t_filter
   task automatic t_cast;
      clr();
      ab <= 1'b0;
      mac.send(14'h64, 4'h4, 4'h1, 16'h0800, 16'h0800);
      ab <= 1'b1;
      mac.send(14'h64, 4'h4, 4'h1, 16'h0800, 16'h0800);
      mac.send(14'h46, 4'h2, 4'h1, 16'h0800, 16'h0800);
      rd(4'h6, 32'h1);
      rd(4'h3, 32'h64);
      rd(4'h7, 32'h1);
      rd(4'h4, 32'h46);
   endtask : t_cast
   task automatic t_strip;
      clr();
      vstrip <= 1'b1;
      fstrip <= 1'b1;
      mac.send(14'h64, 4'h8, 4'h1, VLAN_TPID, 16'h0800);
      mac.send(14'h64, 4'h2, 4'h1, ctag, VLAN_TPID);
      rd(4'h2, 32'h5c);
      rd(4'h4, 32'h58);
      vstrip <= 1'b0;
      fstrip <= 1'b0;
   endtask : t_strip
   task automatic t_over;
      clr();
      max_size <= 14'h64;
      enf <= 1'b1;
      mac.send(14'h65, 4'h8, 4'h1, 16'h0800, 16'h0800);
      mac.send(14'h68, 4'h8, 4'h1, VLAN_TPID, 16'h0800);
      mac.send(14'h69, 4'h8, 4'h1, VLAN_TPID, 16'h0800);
      mac.send(14'h6c, 4'h8, 4'h1, ctag, VLAN_TPID);
      mac.send(14'h6d, 4'h8, 4'h1, ctag, ctag);
      mac.send(14'h64, 4'h8, 4'h9, 16'h0800, 16'h0800);
      mac.send(14'h65, 4'h8, 4'h5, 16'h0800, 16'h0800);
      enf <= 1'b0;
      mac.send(14'h68, 4'h8, 4'h1, VLAN_TPID, 16'h0800);
      rd(4'h0, 32'h4);
      rd(4'h5, 32'h3);
      max_size <= 14'h5ee;
   endtask : t_over
   task automatic t_drop;
      clr();
      mac.send(14'h50, 4'h8, 4'h7, 16'h0800, 16'h0800);
      store <= 1'b1;
      mac.send(14'h50, 4'h8, 4'h7, 16'h0800, 16'h0800);
      rd(4'h1, 32'h1);
      store <= 1'b0;
   endtask : t_drop
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, lite_reset, enf, vstrip, fstrip, fwdp, ab, store, req, sel} = {9'h10c, 4'h0};
      max_size = 14'h5ee;
      ctag = 16'h88a8;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 16; k++) rd(4'(k), 32'h0);
      t_bins();
      t_filter();
      t_cast();
      t_strip();
      t_over();
      t_drop();
      give_verdict();
   end
   initial begin
      #100000;
      miscompares++;
      give_verdict();
   end
endmodule : rxs_stats_tb_top
